// File: logic/serial_core.sv
// Our own choices: the register addresses and register access over APB.
`timescale 1ns/1ps
`default_nettype none
`include "serial_core_regs.svh"
////////////////////////////////////////////////////////////////////////////////
// Function
// - word length 8 or 9 by control bit
// - start bit low, stop bit high
// - idle is whole frame of ones
// - ninth transmit bit from control register
// - shift data least significant bit first
// - enable sends idle frame, disable drops held data
// - tx empty cleared by status then write
// - tx empty set on shift load, interrupts
// - busy write goes to holding buffer
// - idle write loads shifter, starts at once
// - frame sent flag, interrupt, same clearing
// - break bit sends all-zero frames
// - one high bit after last break
// - received ninth bit into control register
// - receive enable starts start-bit search
// - received character fills buffer, sets full
// - rx full cleared by status then read
// - received break is a framing error
// - idle frame acts as character, interrupts
// - overrun keeps buffer, sets flag, interrupts
// - samples eight nine ten, noise flag
// - false start discarded, noise kept hidden
// - framing error flag, data still stored
// - sixteen samples, resync at start bit
module serial_core
    import serial_core_pkg::*;
(
    input  wire logic     clk_i,
    input  wire logic     sys_rst_i,
    input  wire apb_req_t apb_i,
    output apb_rsp_t      apb_o,
    input  wire logic     irq_mask_i,
    input  wire logic     serial_rx_in_i,
    output logic          serial_tx_o,
    output logic          serial_tx_oe_o,
    output logic          irq_o
);
////////////////////////////////////////////////////////////////////////////////
    apb_rsp_t   rsp_reg;
    logic       status_armed_reg;
    logic       word9_reg, tx_ninth_bit_reg, rx_ninth_bit_reg;
    logic       tx_empty_irq_en_reg, done_irq_en_reg, rx_full_irq_en_reg, idle_irq_en_reg;
    logic       tx_enable_reg, rx_enable_reg, send_break_reg;
    logic [15:0] baud_reg;
    logic       tx_buffer_empty_reg, frame_sent_flag_reg;
    logic       rx_buffer_full_reg, idle_flag_reg, overrun_reg;
    logic       noise_flag_reg, framing_error_flag_reg, noise_hidden_reg;
    logic [7:0] tx_holding_buffer_reg, rx_holding_buffer_reg;
    logic       hold_full_reg;
    logic       irq_reg;

    wire setup    = apb_i.psel & ~apb_i.penable;
    wire done_acc = apb_i.psel & apb_i.penable & rsp_reg.pready;
    wire hit_st   = (apb_i.paddr == `OFS_STATUS);
    wire hit_dat  = (apb_i.paddr == `OFS_DATA);
    wire hit_c1   = (apb_i.paddr == `OFS_CTRL1);
    wire hit_c2   = (apb_i.paddr == `OFS_CTRL2);
    wire hit_bd   = (apb_i.paddr == `OFS_BAUD);
    wire mapped   = hit_st | hit_dat | hit_c1 | hit_c2 | hit_bd;
    wire wr       = done_acc & apb_i.pwrite;
    wire data_wr  = wr & hit_dat;
    wire data_rd  = done_acc & ~apb_i.pwrite & hit_dat;
    wire tx_clear = data_wr & status_armed_reg;
    wire rx_clear = data_rd & status_armed_reg;
    wire c2_wr    = wr & hit_c2;
    wire te_new   = apb_i.pwdata[`C2_TX_EN];
    wire te_rise  = c2_wr & te_new & ~tx_enable_reg;
    wire te_fall  = c2_wr & ~te_new & tx_enable_reg;

    logic [7:0] status_v, ctrl1_v, ctrl2_v;
    logic [31:0] rd_mux;
    assign status_v = {tx_buffer_empty_reg, frame_sent_flag_reg, rx_buffer_full_reg,
                       idle_flag_reg, overrun_reg, noise_flag_reg, framing_error_flag_reg, 1'b0};
    assign ctrl1_v  = {rx_ninth_bit_reg, tx_ninth_bit_reg, 1'b0, word9_reg, 4'h0};
    assign ctrl2_v  = {tx_empty_irq_en_reg, done_irq_en_reg, rx_full_irq_en_reg, idle_irq_en_reg,
                       tx_enable_reg, rx_enable_reg, 1'b0, send_break_reg};
    assign rd_mux   = hit_st  ? {24'h0, status_v} :
                      hit_dat ? {24'h0, rx_holding_buffer_reg} :
                      hit_c1  ? {24'h0, ctrl1_v} :
                      hit_c2  ? {24'h0, ctrl2_v} :
                      hit_bd  ? {16'h0, baud_reg} : 32'h0;

    // bus answer: zero wait, data captured in setup
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            rsp_reg <= '0;
        end else begin
            rsp_reg.pready  <= setup;
            rsp_reg.pslverr <= setup & ~mapped;
            rsp_reg.prdata  <= setup ? rd_mux : 32'h0;
        end
    end

    // status access arms the clearing sequence
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            status_armed_reg <= 1'b0;
        end else if (done_acc & hit_st) begin
            status_armed_reg <= 1'b1;
        end else if (data_wr | data_rd) begin
            status_armed_reg <= 1'b0;
        end
    end

    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            word9_reg           <= 1'b0;
            tx_ninth_bit_reg    <= 1'b0;
            tx_empty_irq_en_reg <= 1'b0;
            done_irq_en_reg     <= 1'b0;
            rx_full_irq_en_reg  <= 1'b0;
            idle_irq_en_reg     <= 1'b0;
            tx_enable_reg       <= 1'b0;
            rx_enable_reg       <= 1'b0;
            send_break_reg      <= 1'b0;
            baud_reg            <= `BAUD_RST;
        end else begin
            if (wr & hit_c1) begin
                word9_reg        <= apb_i.pwdata[`C1_WORD9];
                tx_ninth_bit_reg <= apb_i.pwdata[`C1_TX_NINTH];
            end
            if (c2_wr) begin
                tx_empty_irq_en_reg <= apb_i.pwdata[`C2_TX_EMPTY_IE];
                done_irq_en_reg     <= apb_i.pwdata[`C2_DONE_IE];
                rx_full_irq_en_reg  <= apb_i.pwdata[`C2_RX_FULL_IE];
                idle_irq_en_reg     <= apb_i.pwdata[`C2_IDLE_IE];
                tx_enable_reg       <= te_new;
                rx_enable_reg       <= apb_i.pwdata[`C2_RX_EN];
                send_break_reg      <= apb_i.pwdata[`C2_BREAK];
            end
            if (wr & hit_bd) begin
                baud_reg <= apb_i.pwdata[15:0];
            end
        end
    end

////////////////////////////////////////////////////////////////////////////////
    // transmitter
    logic       tx_tick, rx_tick;
    tx_state_t  tx_state_reg;
    logic [10:0] tx_frame_reg;
    logic [3:0] tx_bits_reg, tx_cnt_reg;
    logic       idle_pending_reg, after_break_reg, tx_out_reg, tx_oe_reg;
    logic       tx_done;

    baud_tick #(.W(16)) u_tx_tick (
        .clk_i     (clk_i),
        .sys_rst_i (sys_rst_i),
        .divisor_i (baud_reg),
        .tick_o    (tx_tick)
    );

    wire [3:0]  frame_bits = word9_reg ? `BITS_WORD9 : `BITS_WORD8;
    wire        pad_bit    = word9_reg ? tx_ninth_bit_reg : 1'b1;
    wire [10:0] data_frame = {1'b1, pad_bit, tx_holding_buffer_reg, 1'b0};
    wire        tx_free    = (tx_state_reg == TX_IDLE) & tx_enable_reg;
    wire        load_brk   = tx_free & send_break_reg;
    wire        load_one   = tx_free & ~send_break_reg & after_break_reg;
    wire        load_idle  = tx_free & ~send_break_reg & ~after_break_reg & idle_pending_reg;
    wire        load_data  = tx_free & ~send_break_reg & ~after_break_reg & ~idle_pending_reg
                           & hold_full_reg;
    assign tx_done = (tx_state_reg == TX_BUSY) & tx_tick & (tx_cnt_reg == `TICK_LAST)
                   & (tx_bits_reg == 4'h1);

    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            tx_state_reg <= TX_IDLE;
            tx_frame_reg <= '1;
            tx_bits_reg  <= '0;
            tx_cnt_reg   <= '0;
            after_break_reg <= 1'b0;
        end else begin
            case (tx_state_reg)
                TX_IDLE: begin
                    tx_cnt_reg <= '0;
                    if (load_brk) begin
                        tx_frame_reg    <= '0;
                        tx_bits_reg     <= frame_bits;
                        after_break_reg <= 1'b1;
                        tx_state_reg    <= TX_BUSY;
                    end else if (load_one) begin
                        tx_frame_reg    <= '1;
                        tx_bits_reg     <= 4'h1;
                        after_break_reg <= 1'b0;
                        tx_state_reg    <= TX_BUSY;
                    end else if (load_idle) begin
                        tx_frame_reg <= '1;
                        tx_bits_reg  <= frame_bits;
                        tx_state_reg <= TX_BUSY;
                    end else if (load_data) begin
                        tx_frame_reg <= data_frame;
                        tx_bits_reg  <= frame_bits;
                        tx_state_reg <= TX_BUSY;
                    end
                end
                TX_BUSY: begin
                    if (tx_tick) begin
                        tx_cnt_reg <= tx_cnt_reg + 4'h1;
                        if (tx_cnt_reg == `TICK_LAST) begin
                            tx_frame_reg <= {1'b1, tx_frame_reg[10:1]};
                            tx_bits_reg  <= tx_bits_reg - 4'h1;
                            if (tx_bits_reg == 4'h1) begin
                                tx_state_reg <= TX_IDLE;
                            end
                        end
                    end
                end
                default: tx_state_reg <= TX_IDLE;
            endcase
        end
    end

    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            idle_pending_reg      <= 1'b0;
            hold_full_reg         <= 1'b0;
            tx_holding_buffer_reg <= '0;
        end else begin
            if (te_rise) begin
                idle_pending_reg <= 1'b1;
            end else if (load_idle) begin
                idle_pending_reg <= 1'b0;
            end
            if (data_wr) begin
                tx_holding_buffer_reg <= apb_i.pwdata[7:0];
                hold_full_reg         <= 1'b1;
            end else if (te_fall | load_data) begin
                hold_full_reg <= 1'b0;
            end
        end
    end

    // flags: hardware set wins over software clear
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            tx_buffer_empty_reg <= 1'b1;
            frame_sent_flag_reg <= 1'b1;
        end else begin
            if (load_data) begin
                tx_buffer_empty_reg <= 1'b1;
            end else if (tx_clear) begin
                tx_buffer_empty_reg <= 1'b0;
            end
            if (tx_done) begin
                frame_sent_flag_reg <= 1'b1;
            end else if (tx_clear) begin
                frame_sent_flag_reg <= 1'b0;
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            tx_out_reg <= 1'b1;
            tx_oe_reg  <= 1'b0;
        end else begin
            tx_out_reg <= (tx_state_reg == TX_BUSY) ? tx_frame_reg[0] : 1'b1;
            tx_oe_reg  <= tx_enable_reg | rx_enable_reg | (tx_state_reg == TX_BUSY);
        end
    end

////////////////////////////////////////////////////////////////////////////////
    // receiver
    logic       rx_meta_reg, rxd_reg;
    rx_state_t  rx_state_reg;
    logic [3:0] rx_cnt_reg, rx_bit_reg;
    logic [1:0] samp_reg;
    logic [8:0] rx_shift_reg;
    logic       rx_noise_reg, line_high_reg, idle_seen_reg;
    logic [7:0] idle_cnt_reg;
    logic       vbit, vnoisy;

    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            rx_meta_reg <= 1'b1;
            rxd_reg     <= 1'b1;
        end else begin
            rx_meta_reg <= serial_rx_in_i;
            rxd_reg     <= rx_meta_reg;
        end
    end

    baud_tick #(.W(16)) u_rx_tick (
        .clk_i     (clk_i),
        .sys_rst_i (sys_rst_i),
        .divisor_i (baud_reg),
        .tick_o    (rx_tick)
    );

    vote3 u_vote (
        .samples_i ({rxd_reg, samp_reg}),
        .bit_o     (vbit),
        .noisy_o   (vnoisy)
    );

    wire       hunt      = rx_enable_reg & (rx_state_reg == RX_HUNT);
    wire       start_det = hunt & rx_tick & line_high_reg & ~rxd_reg;
    wire       decide    = (rx_state_reg == RX_FRAME) & rx_tick & (rx_cnt_reg == `SAMPLE_C);
    wire       false_st  = decide & (rx_bit_reg == 4'h0) & vbit;
    wire [3:0] stop_pos  = frame_bits - 4'h1;
    wire       char_done = decide & (rx_bit_reg == stop_pos);
    wire [7:0] idle_len  = word9_reg ? `IDLE_TICKS9 : `IDLE_TICKS8;
    wire       idle_det  = hunt & rx_tick & rxd_reg & ~idle_seen_reg
                         & (idle_cnt_reg == idle_len - 8'h1);
    wire       got_char  = char_done | idle_det;
    wire [7:0] rx_byte   = word9_reg ? rx_shift_reg[7:0] : rx_shift_reg[8:1];

    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            rx_state_reg  <= RX_HUNT;
            rx_cnt_reg    <= '0;
            rx_bit_reg    <= '0;
            samp_reg      <= '0;
            rx_shift_reg  <= '0;
            line_high_reg <= 1'b0;
        end else if (~rx_enable_reg) begin
            rx_state_reg  <= RX_HUNT;
            line_high_reg <= 1'b0;
        end else begin
            case (rx_state_reg)
                RX_HUNT: begin
                    if (rx_tick) begin
                        line_high_reg <= rxd_reg;
                    end
                    if (start_det) begin
                        rx_cnt_reg   <= `SAMPLE_NEXT;
                        rx_bit_reg   <= '0;
                        rx_state_reg <= RX_FRAME;
                    end
                end
                RX_FRAME: begin
                    if (rx_tick) begin
                        rx_cnt_reg <= rx_cnt_reg + 4'h1;
                        if (rx_cnt_reg == `SAMPLE_A || rx_cnt_reg == `SAMPLE_B) begin
                            samp_reg <= {rxd_reg, samp_reg[1]};
                        end
                        if (rx_cnt_reg == `TICK_LAST) begin
                            rx_bit_reg <= rx_bit_reg + 4'h1;
                        end
                        if (decide) begin
                            if (false_st || char_done) begin
                                rx_state_reg  <= RX_HUNT;
                                line_high_reg <= 1'b0;
                            end else if (rx_bit_reg != 4'h0) begin
                                rx_shift_reg <= {vbit, rx_shift_reg[8:1]};
                            end
                        end
                    end
                end
                default: rx_state_reg <= RX_HUNT;
            endcase
        end
    end

    // noise gathered over the frame, kept across false starts
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            rx_noise_reg <= 1'b0;
        end else if (got_char) begin
            rx_noise_reg <= 1'b0;
        end else if (decide & vnoisy) begin
            rx_noise_reg <= 1'b1;
        end
    end
    assign noise_hidden_reg = rx_noise_reg;

    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            idle_cnt_reg  <= '0;
            idle_seen_reg <= 1'b0;
        end else if (~hunt | ~rxd_reg) begin
            idle_cnt_reg  <= '0;
            idle_seen_reg <= 1'b0;
        end else if (rx_tick & ~idle_seen_reg) begin
            idle_cnt_reg  <= idle_cnt_reg + 8'h1;
            idle_seen_reg <= idle_det;
        end
    end

    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            rx_buffer_full_reg     <= 1'b0;
            idle_flag_reg          <= 1'b0;
            overrun_reg            <= 1'b0;
            noise_flag_reg         <= 1'b0;
            framing_error_flag_reg <= 1'b0;
            rx_holding_buffer_reg  <= '0;
            rx_ninth_bit_reg       <= 1'b0;
        end else begin
            if (got_char & rx_buffer_full_reg) begin
                overrun_reg <= 1'b1;
            end else if (rx_clear) begin
                overrun_reg <= 1'b0;
            end
            if (got_char & ~rx_buffer_full_reg) begin
                rx_buffer_full_reg     <= 1'b1;
                noise_flag_reg         <= noise_hidden_reg | (char_done & vnoisy);
                framing_error_flag_reg <= char_done & ~vbit;
                idle_flag_reg          <= idle_det;
                rx_holding_buffer_reg  <= char_done ? rx_byte : 8'hff;
                rx_ninth_bit_reg       <= word9_reg & char_done & rx_shift_reg[8];
            end else if (rx_clear) begin
                rx_buffer_full_reg     <= 1'b0;
                noise_flag_reg         <= 1'b0;
                framing_error_flag_reg <= 1'b0;
                idle_flag_reg          <= 1'b0;
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            irq_reg <= 1'b0;
        end else begin
            irq_reg <= ~irq_mask_i & ((tx_buffer_empty_reg & tx_empty_irq_en_reg)
                     | (frame_sent_flag_reg & done_irq_en_reg)
                     | ((rx_buffer_full_reg | overrun_reg) & rx_full_irq_en_reg)
                     | (idle_flag_reg & idle_irq_en_reg));
        end
    end

    assign apb_o          = rsp_reg;
    assign serial_tx_o    = tx_out_reg;
    assign serial_tx_oe_o = tx_oe_reg;
    assign irq_o          = irq_reg;

////////////////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (sys_rst_i);

    AST_START_LOW: assert property (load_data |=> ##1 ~serial_tx_o)
        else $error("start bit not low");
    AST_IDLE_HIGH: assert property (load_idle |=> ##1 serial_tx_o)
        else $error("idle frame not high");
    AST_BREAK_LOW: assert property (load_brk |=> ##1 ~serial_tx_o)
        else $error("break not low");
    AST_TX_BUFFER_EMPTY_CLR: assert property ($fell(tx_buffer_empty_reg) |-> $past(tx_clear))
        else $error("tx empty cleared without sequence");
    AST_TX_BUFFER_EMPTY_SET: assert property (load_data |=> tx_buffer_empty_reg)
        else $error("tx empty not set on load");
    AST_SENT: assert property (tx_done |=> frame_sent_flag_reg)
        else $error("frame sent flag missing");
    AST_RX_BUFFER_FULL_CLR: assert property ($fell(rx_buffer_full_reg) |-> $past(rx_clear))
        else $error("rx full cleared without sequence");
    AST_OVR_KEEP: assert property (got_char & rx_buffer_full_reg |=> overrun_reg
                                  && $stable(rx_holding_buffer_reg))
        else $error("overrun handling wrong");
    AST_FALSE: assert property (false_st |=> ~rx_buffer_full_reg || $past(rx_buffer_full_reg))
        else $error("false start filled buffer");
    AST_IRQ: assert property (rx_buffer_full_reg & rx_full_irq_en_reg & ~irq_mask_i |=> irq_o)
        else $error("rx interrupt missing");
    COV_TX: cover property (tx_done);
    COV_RX: cover property (char_done & ~rx_buffer_full_reg);
    COV_OVR: cover property (got_char & rx_buffer_full_reg);
    COV_IDLE: cover property (idle_det);
endmodule
`default_nettype wire

// File: logic/serial_core_regs.svh
`ifndef SERIAL_CORE_REGS_SVH
`define SERIAL_CORE_REGS_SVH
// register byte offsets
`define OFS_STATUS      8'h00
`define OFS_DATA        8'h04
`define OFS_CTRL1       8'h08
`define OFS_CTRL2       8'h0c
`define OFS_BAUD        8'h10
// status_register fields
`define ST_TX_EMPTY     7
`define ST_SENT         6
`define ST_RX_FULL      5
`define ST_IDLE         4
`define ST_OVERRUN      3
`define ST_NOISE        2
`define ST_FRAMING      1
// control_register_1 fields
`define C1_RX_NINTH     7
`define C1_TX_NINTH     6
`define C1_WORD9        4
// control_register_2 fields
`define C2_TX_EMPTY_IE  7
`define C2_DONE_IE      6
`define C2_RX_FULL_IE   5
`define C2_IDLE_IE      4
`define C2_TX_EN        3
`define C2_RX_EN        2
`define C2_BREAK        0
// reset values
`define BAUD_RST        16'h0001
// sampling figures
`define TICK_LAST       4'hf
`define SAMPLE_A        4'h8
`define SAMPLE_B        4'h9
`define SAMPLE_C        4'ha
`define SAMPLE_NEXT     4'h2
`define BITS_WORD8      4'ha
`define BITS_WORD9      4'hb
`define IDLE_TICKS8     8'ha0
`define IDLE_TICKS9     8'hb0
`endif

// File: logic/serial_core_pkg.sv
`default_nettype none
package serial_core_pkg;
    typedef struct packed {
        logic        psel;
        logic        penable;
        logic        pwrite;
        logic [7:0]  paddr;
        logic [31:0] pwdata;
    } apb_req_t;
    typedef struct packed {
        logic        pready;
        logic        pslverr;
        logic [31:0] prdata;
    } apb_rsp_t;
    typedef enum logic {TX_IDLE, TX_BUSY} tx_state_t;
    typedef enum logic [1:0] {RX_HUNT, RX_FRAME} rx_state_t;
endpackage
`default_nettype wire

// File: logic/baud_tick.sv
`timescale 1ns/1ps
`default_nettype none
module baud_tick #(
    parameter int W = 16
) (
    input  wire logic         clk_i,
    input  wire logic         sys_rst_i,
    input  wire logic [W-1:0] divisor_i,
    output logic              tick_o
);
    logic [W-1:0] cnt_reg;
    logic         tick_reg;
    wire          wrap = (cnt_reg <= W'(1));

    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            cnt_reg  <= '0;
            tick_reg <= 1'b0;
        end else begin
            cnt_reg  <= wrap ? divisor_i : cnt_reg - W'(1);
            tick_reg <= wrap;
        end
    end
    assign tick_o = tick_reg;
endmodule
`default_nettype wire

// File: logic/vote3.sv
`timescale 1ns/1ps
`default_nettype none
module vote3 (
    input  wire logic [2:0] samples_i,
    output logic            bit_o,
    output logic            noisy_o
);
    assign bit_o   = (samples_i[0] & samples_i[1]) | (samples_i[1] & samples_i[2])
                   | (samples_i[0] & samples_i[2]);
    assign noisy_o = (samples_i != 3'h0) && (samples_i != 3'h7);
endmodule
`default_nettype wire

// File: tb/far_end.sv
`timescale 1ns/1ps
`default_nettype none
module far_end (
    input  wire logic  clk_i,
    input  wire logic  line_i,
    input  wire logic  nine_i,
    output logic       line_o,
    output logic [8:0] got_o,
    output logic       done_o
);
    initial begin
        line_o = 1'b1;
        got_o = 9'h000;
        done_o = 1'b0;
        forever begin
            @(negedge line_i);
            got_o = 9'h000;
            repeat (8) @(posedge clk_i);
            for (int i = 0; i < (nine_i ? 9 : 8); i++) begin
                repeat (16) @(posedge clk_i);
                got_o[i] = line_i;
            end
            repeat (16) @(posedge clk_i);
            if (line_i) done_o = ~done_o;
        end
    end
    task automatic send(input logic [8:0] d, input logic nine, input logic stop);
        @(posedge clk_i);
        line_o <= 1'b0;
        for (int i = 0; i < (nine ? 10 : 9); i++) begin
            repeat (16) @(posedge clk_i);
            line_o <= (i == (nine ? 9 : 8)) ? stop : d[i];
        end
        repeat (16) @(posedge clk_i);
        line_o <= 1'b1;
    endtask
endmodule
`default_nettype wire

// File: tb/test_async_serial_tx_rx_core.sv
`timescale 1ns/1ps
`default_nettype none
`include "serial_core_regs.svh"
module test_async_serial_tx_rx_core
    import serial_core_pkg::*;
;
    typedef struct packed {logic nine; logic [8:0] d; logic [8:0] e;} row_t;
    row_t        rows [3] = '{'{1'b0, 9'h155, 9'h055}, '{1'b0, 9'h0a3, 9'h0a3}, '{1'b1, 9'h1c5, 9'h1c5}};
    logic        clk_i, sys_rst_i, irq_mask_i, nine, tx_w, oe_w, irq_w, rx_w, done_w, er, s;
    logic [8:0]  got_w;
    logic [31:0] rd;
    apb_req_t    apb_i;
    apb_rsp_t    apb_o;
    int          errors, num_checks;
    serial_core serial_core_i (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .apb_i(apb_i), .apb_o(apb_o),
        .irq_mask_i(irq_mask_i), .serial_rx_in_i(rx_w), .serial_tx_o(tx_w), .serial_tx_oe_o(oe_w), .irq_o(irq_w));
    far_end far_end_i (.clk_i(clk_i), .line_i(tx_w), .nine_i(nine), .line_o(rx_w), .got_o(got_w), .done_o(done_w));
    initial begin
        clk_i = 1'b0;
        forever #5 clk_i = ~clk_i;
    end
    ////////////////////////////////////////////////////////////////////////////////
    task automatic end_of_test;
        if (errors == 0 && num_checks > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    task automatic quit;
        errors++;
        end_of_test();
    endtask
    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        num_checks++;
        if (g !== e) begin
            errors++;
            $display("MISMATCH %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d = 32'h0);
        int k;
        @(posedge clk_i);
        apb_i <= '{1'b1, 1'b0, w, a, d};
        @(posedge clk_i);
        apb_i.penable <= 1'b1;
        k = 0;
        do begin
            @(posedge clk_i);
            k++;
        end while (apb_o.pready !== 1'b1 && k < 20);
        rd = apb_o.prdata;
        er = apb_o.pslverr;
        apb_i <= '0;
        if (k == 20) quit();
    endtask
    task automatic wait_rx;
        int k;
        k = 0;
        do begin
            apb(1'b0, `OFS_STATUS);
            k++;
        end while (rd[`ST_RX_FULL] !== 1'b1 && k < 200);
        if (k == 200) quit();
    endtask
    task automatic drain;
        apb(1'b0, `OFS_STATUS);
        apb(1'b0, `OFS_DATA);
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        apb_i = '0;
        irq_mask_i = 1'b1;
        nine = 1'b0;
        sys_rst_i = 1'b1;
        repeat (4) @(posedge clk_i);
        chk("tx_rst", 32'h1, {31'h0, tx_w});
        chk("oe_rst", 32'h0, {31'h0, oe_w});
        sys_rst_i <= 1'b0;
        apb(1'b0, `OFS_STATUS);
        chk("status_rst", 32'hc0, rd);
        apb(1'b0, `OFS_BAUD);
        chk("baud_rst", 32'h1, rd);
        apb(1'b0, 8'h14);
        chk("unmapped", 32'h1, {31'h0, er});
        apb(1'b1, `OFS_CTRL2, 32'h2c);
        irq_mask_i <= 1'b0;
        foreach (rows[i]) begin
            nine <= rows[i].nine;
            apb(1'b1, `OFS_CTRL1, {25'h0, rows[i].d[8], 1'b0, rows[i].nine, 4'h0});
            apb(1'b0, `OFS_STATUS);
            s = done_w;
            apb(1'b1, `OFS_DATA, {24'h0, rows[i].d[7:0]});
            apb(1'b0, `OFS_STATUS);
            chk("tx_flags", (i == 0) ? 32'h0 : 32'h80, rd & 32'hc0);
            for (int k = 0; done_w === s; k++) if (k < 600) @(posedge clk_i); else quit();
            chk("tx_word", {23'h0, rows[i].e}, {23'h0, got_w});
            apb(1'b0, `OFS_STATUS);
            chk("idle_flag", 32'h30, rd & 32'h30);
            apb(1'b0, `OFS_DATA);
            chk("idle_data", 32'hff, rd);
            far_end_i.send(rows[i].d, rows[i].nine, 1'b1);
            wait_rx();
            chk("tx_done", 32'hc0, rd & 32'hc0);
            chk("irq", 32'h1, {31'h0, irq_w});
            apb(1'b0, `OFS_DATA);
            chk("rx_data", {24'h0, rows[i].e[7:0]}, rd);
            apb(1'b0, `OFS_CTRL1);
            chk("rx_ninth", {31'h0, rows[i].e[8]}, {31'h0, rd[7]});
        end
        drain();
        far_end_i.send(9'h03c, 1'b1, 1'b1);
        far_end_i.send(9'h0c3, 1'b1, 1'b1);
        wait_rx();
        chk("overrun", 32'h28, rd & 32'h2e);
        apb(1'b0, `OFS_DATA);
        chk("ovr_keep", 32'h3c, rd);
        drain();
        far_end_i.send(9'h000, 1'b1, 1'b0);
        wait_rx();
        chk("framing", 32'h22, rd & 32'h22);
        apb(1'b0, `OFS_DATA);
        chk("brk_data", 32'h0, rd);
        chk("oe_on", 32'h1, {31'h0, oe_w});
        apb(1'b1, `OFS_CTRL2, 32'h2d);
        repeat (40) @(posedge clk_i);
        chk("break_line", 32'h0, {31'h0, tx_w});
        apb(1'b1, `OFS_CTRL2, 32'h2c);
        repeat (400) @(posedge clk_i);
        chk("break_end", 32'h1, {31'h0, tx_w});
        sys_rst_i <= 1'b1;
        repeat (2) @(posedge clk_i);
        sys_rst_i <= 1'b0;
        apb(1'b0, `OFS_CTRL2);
        chk("ctrl2_rst", 32'h0, rd);
        chk("oe_rst2", 32'h0, {31'h0, oe_w});
        end_of_test();
    end
endmodule
`default_nettype wire
